// >>> src/rcc_pkg.sv
package rcc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [1:0] ADDR_REFCTL = 2'h0;
  localparam logic [1:0] ADDR_AUXCTL = 2'h1;
  localparam logic [1:0] ADDR_AUXDIV = 2'h2;
  localparam logic [15:0] RST_REFCTL = 16'h0000;
  localparam logic [15:0] RST_AUXCTL = 16'h0000;
  localparam logic [15:0] RST_AUXDIV = 16'h0000;
  // Writable bit masks; other bits read as zero
  localparam logic [15:0] MASK_REFCTL = 16'hBF00;
  localparam logic [15:0] MASK_AUXCTL = 16'hBEE7;
  localparam logic [15:0] MASK_AUXDIV = 16'h0007;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int REF_ON_BIT    = 15;
  localparam int REF_SLEEP_BIT = 13;
  localparam int REF_SRC_BIT   = 12;
  localparam int REF_DIV_LSB   = 8;
  localparam int AUX_PLLEN_BIT = 15;
  localparam int AUX_DSRC_BIT  = 13;
  localparam int AUX_MODE_LSB  = 11;
  localparam int AUX_PREF_BIT  = 10;
  localparam int AUX_FRC_BIT   = 9;
  localparam int AUX_POST_LSB  = 5;
  localparam int AUX_PRE_LSB   = 0;
  localparam int AUX_MULT_LSB  = 0;
  localparam int REF_DIV_W     = 4;
  localparam int REF_CNT_W     = 16;
  typedef enum logic [1:0] {
    AOSC_OFF, AOSC_HS, AOSC_XT, AOSC_EC
  } rcc_aosc_mode_t;
  typedef enum logic [1:0] {
    PSRC_AUX_OSC, PSRC_PRI_OSC, PSRC_FRC
  } rcc_pll_src_t;
endpackage

// >>> src/rcc_pow2_div.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_pow2_div #(
  parameter int CNT_W = 16,
  parameter int SEL_W = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Control
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [SEL_W-1:0] sel,
  // Divided level
  output logic                  div_out
);
  logic [CNT_W-1:0] cnt_r;
  // Ticks mark half-periods, so bit 0 is the source itself and bit n
  // is the source divided by two to the n
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  assign div_out = cnt_r[sel];
endmodule
`default_nettype wire

// >>> src/rcc_clock_ctrl.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rcc_clock_ctrl (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // Register port
  input  wire logic [1:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  // Source clock enables, one pulse per source half-period, and the sleep input
  input  wire logic        SYS_CLK_TICK,
  input  wire logic        XTAL_CLK_TICK,
  input  wire logic        SLEEP,
  // Reference output pin
  output logic             REF_CLOCK_OUT_PIN,
  output logic             REF_CLOCK_OUT_PIN_OE,
  // Auxiliary path controls
  output logic             AUX_PLL_ENABLE,
  output logic             USB_CLK_FROM_PLL,
  output logic             AUX_DIVIDER_FROM_AUX,
  output logic      [1:0]  AUX_OSC_MODE,
  output logic      [1:0]  AUX_PLL_SOURCE,
  output logic      [8:0]  AUX_PLL_OUT_DIV,
  output logic      [3:0]  AUX_PLL_PRE_DIV,
  output logic      [4:0]  AUX_PLL_MULT
);
  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] ref_ctl_r;
  logic [15:0] aux_ctl_r;
  logic [15:0] aux_div_r;
  logic [15:0] rdata_r;
  wire wr_ref = WR && (ADDR == rcc_pkg::ADDR_REFCTL);
  wire wr_aux = WR && (ADDR == rcc_pkg::ADDR_AUXCTL);
  wire wr_div = WR && (ADDR == rcc_pkg::ADDR_AUXDIV);
  wire [15:0] rd_sel =
    (ADDR == rcc_pkg::ADDR_REFCTL) ? ref_ctl_r :
    (ADDR == rcc_pkg::ADDR_AUXCTL) ? aux_ctl_r :
    (ADDR == rcc_pkg::ADDR_AUXDIV) ? aux_div_r : 16'h0000;
  // Divider writes while enabled are kept; software must disable first
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ref_ctl_r <= rcc_pkg::RST_REFCTL;
      aux_ctl_r <= rcc_pkg::RST_AUXCTL;
      aux_div_r <= rcc_pkg::RST_AUXDIV;
      rdata_r   <= 16'h0000;
    end else begin
      if (wr_ref)
        ref_ctl_r <= WDATA & rcc_pkg::MASK_REFCTL;
      if (wr_aux)
        aux_ctl_r <= WDATA & rcc_pkg::MASK_AUXCTL;
      if (wr_div)
        aux_div_r <= WDATA & rcc_pkg::MASK_AUXDIV;
      rdata_r <= RD ? rd_sel : 16'h0000;
    end
  end
  assign RDATA = rdata_r;
  // ****************************************
  // Reference clock output
  // ****************************************
  wire ref_on   = ref_ctl_r[rcc_pkg::REF_ON_BIT];
  wire ref_slp  = ref_ctl_r[rcc_pkg::REF_SLEEP_BIT];
  wire ref_src  = ref_ctl_r[rcc_pkg::REF_SRC_BIT];
  wire [3:0] ref_div = ref_ctl_r[rcc_pkg::REF_DIV_LSB +: 4];
  wire ref_run  = ref_on && (!SLEEP || ref_slp);
  wire ref_tick = ref_src ? XTAL_CLK_TICK : SYS_CLK_TICK;
  wire ref_lvl;
  rcc_pow2_div #(
    .CNT_W (rcc_pkg::REF_CNT_W),
    .SEL_W (rcc_pkg::REF_DIV_W)
  ) u_div (
    .clk     (REF_CLK),
    .rst     (RST),
    .run     (ref_run),
    .tick    (ref_tick),
    .sel     (ref_div),
    .div_out (ref_lvl)
  );
  // ****************************************
  // Auxiliary decodes
  // ****************************************
  wire [2:0] post = aux_ctl_r[rcc_pkg::AUX_POST_LSB +: 3];
  wire [2:0] pre  = aux_ctl_r[rcc_pkg::AUX_PRE_LSB +: 3];
  wire [2:0] mul  = aux_div_r[rcc_pkg::AUX_MULT_LSB +: 3];
  wire [8:0] post_nxt =
    (post == 3'h0) ? 9'h100 :
    (post[2:1] == 2'h3) ? 9'h002 :
    (9'h001 << (3'h7 - post));
  wire [3:0] pre_nxt =
    (pre == 3'h7) ? 4'hC :
    (pre == 3'h6) ? 4'hA :
    (pre == 3'h5) ? 4'h6 :
    {1'b0, pre} + 4'h1;
  wire [4:0] mul_nxt =
    (mul == 3'h7) ? 5'h18 :
    (mul == 3'h6) ? 5'h15 :
    (mul == 3'h5) ? 5'h14 :
    {2'h0, mul} + 5'h0F;
  wire [1:0] src_nxt =
    aux_ctl_r[rcc_pkg::AUX_FRC_BIT] ? 2'(rcc_pkg::PSRC_FRC) :
    aux_ctl_r[rcc_pkg::AUX_PREF_BIT] ? 2'(rcc_pkg::PSRC_PRI_OSC) :
    2'(rcc_pkg::PSRC_AUX_OSC);
  // Registered so every top output is a flip-flop
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      REF_CLOCK_OUT_PIN    <= 1'b0;
      REF_CLOCK_OUT_PIN_OE <= 1'b0;
      AUX_PLL_ENABLE       <= 1'b0;
      USB_CLK_FROM_PLL     <= 1'b0;
      AUX_DIVIDER_FROM_AUX <= 1'b0;
      AUX_OSC_MODE         <= 2'h0;
      AUX_PLL_SOURCE       <= 2'h0;
      AUX_PLL_OUT_DIV      <= 9'h100;
      AUX_PLL_PRE_DIV      <= 4'h1;
      AUX_PLL_MULT         <= 5'h0F;
    end else begin
      REF_CLOCK_OUT_PIN    <= ref_run && ref_lvl;
      REF_CLOCK_OUT_PIN_OE <= ref_on;
      AUX_PLL_ENABLE       <= aux_ctl_r[rcc_pkg::AUX_PLLEN_BIT];
      USB_CLK_FROM_PLL     <= aux_ctl_r[rcc_pkg::AUX_PLLEN_BIT];
      AUX_DIVIDER_FROM_AUX <= aux_ctl_r[rcc_pkg::AUX_DSRC_BIT];
      AUX_OSC_MODE <= aux_ctl_r[rcc_pkg::AUX_MODE_LSB +: 2];
      AUX_PLL_SOURCE       <= src_nxt;
      AUX_PLL_OUT_DIV      <= post_nxt;
      AUX_PLL_PRE_DIV      <= pre_nxt;
      AUX_PLL_MULT         <= mul_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> dv/rcc_clock_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_clock_ctrl_sva (
  // Clock, reset and write side of the register port
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic [1:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  // Decoded outputs
  input wire logic        REF_CLOCK_OUT_PIN,
  input wire logic        REF_CLOCK_OUT_PIN_OE,
  input wire logic        AUX_PLL_ENABLE,
  input wire logic        USB_CLK_FROM_PLL,
  input wire logic        AUX_DIVIDER_FROM_AUX,
  input wire logic [1:0]  AUX_OSC_MODE,
  input wire logic [1:0]  AUX_PLL_SOURCE,
  input wire logic [8:0]  AUX_PLL_OUT_DIV,
  input wire logic [3:0]  AUX_PLL_PRE_DIV,
  input wire logic [4:0]  AUX_PLL_MULT
);
  // ****
  // Write tracking
  // ****
  // Outputs land two edges after a write, so keep that old write data
  logic [15:0] w1_r;
  logic [15:0] w2_r;
  always_ff @(posedge REF_CLK) begin
    w1_r <= WDATA;
    w2_r <= w1_r;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence wr_ref; WR && ADDR == rcc_pkg::ADDR_REFCTL; endsequence
  sequence wr_aux; WR && ADDR == rcc_pkg::ADDR_AUXCTL; endsequence
  sequence wr_div; WR && ADDR == rcc_pkg::ADDR_AUXDIV; endsequence
  a_ref_oe_follow: assert property (wr_ref |-> ##2
    REF_CLOCK_OUT_PIN_OE == w2_r[15]) else $error("output enable wrong");
  a_pin_low_off: assert property (!REF_CLOCK_OUT_PIN_OE [*3] |->
    !REF_CLOCK_OUT_PIN) else $error("pin not low while disabled");
  a_usb_from_pll: assert property (wr_aux |-> ##2
    AUX_PLL_ENABLE == w2_r[15] && USB_CLK_FROM_PLL == w2_r[15])
    else $error("pll enable or usb select wrong");
  a_div_src: assert property (wr_aux |-> ##2
    AUX_DIVIDER_FROM_AUX == w2_r[13]) else $error("divider source wrong");
  a_osc_mode: assert property (wr_aux |-> ##2
    AUX_OSC_MODE == w2_r[12:11]) else $error("oscillator mode wrong");
  a_pll_src: assert property (wr_aux |-> ##2
    AUX_PLL_SOURCE == (w2_r[9] ? 2'h2 : {1'b0, w2_r[10]}))
    else $error("pll source wrong");
  a_post_div: assert property (wr_aux |-> ##2 AUX_PLL_OUT_DIV ==
    (w2_r[7:6] == 2'h3 ? 9'h002 : w2_r[7:5] == 3'h0 ? 9'h100 :
    9'h001 << (3'h7 - w2_r[7:5]))) else $error("output divider wrong");
  a_pre_div: assert property (wr_aux |-> ##2 AUX_PLL_PRE_DIV ==
    (w2_r[2:0] == 3'h7 ? 4'hC : w2_r[2:0] == 3'h6 ? 4'hA :
    w2_r[2:0] == 3'h5 ? 4'h6 : {1'b0, w2_r[2:0]} + 4'h1))
    else $error("prescaler wrong");
  a_mult_ratio: assert property (wr_div |-> ##2 AUX_PLL_MULT ==
    (w2_r[2:0] == 3'h7 ? 5'h18 : w2_r[2:0] == 3'h6 ? 5'h15 :
    {2'h0, w2_r[2:0]} + 5'h0F)) else $error("multiplier wrong");
endmodule
bind rcc_clock_ctrl rcc_clock_ctrl_sva u_sva (.REF_CLK, .RST, .ADDR, .WDATA,
  .WR, .REF_CLOCK_OUT_PIN, .REF_CLOCK_OUT_PIN_OE, .AUX_PLL_ENABLE,
  .USB_CLK_FROM_PLL, .AUX_DIVIDER_FROM_AUX, .AUX_OSC_MODE, .AUX_PLL_SOURCE,
  .AUX_PLL_OUT_DIV, .AUX_PLL_PRE_DIV, .AUX_PLL_MULT);
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****
  // Bench
  // ****
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, st = 1'b0;
  logic        xt = 1'b0, slp = 1'b0, pin, oe, pen, usb, fax;
  logic [1:0]  adr = 2'h0, mode, src;
  logic [15:0] wd = 16'h0000, rdat, w;
  logic [8:0]  post;
  logic [3:0]  pre;
  logic [4:0]  mult;
  logic [2:0]  c;
  int          fails = 0, checks_done = 0, n;
  logic [8:0]  post_e [8] = '{9'h100, 9'h040, 9'h020, 9'h010, 9'h008,
                              9'h004, 9'h002, 9'h002};
  logic [3:0]  pre_e [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};
  logic [4:0]  mul_e [8] = '{5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
                             5'h15, 5'h18};
  always #4 clk = ~clk;
  rcc_clock_ctrl DUT (.REF_CLK(clk), .RST(rst), .ADDR(adr), .WDATA(wd),
    .WR(wr), .RD(rd), .RDATA(rdat), .SYS_CLK_TICK(st), .XTAL_CLK_TICK(xt),
    .SLEEP(slp), .REF_CLOCK_OUT_PIN(pin), .REF_CLOCK_OUT_PIN_OE(oe),
    .AUX_PLL_ENABLE(pen), .USB_CLK_FROM_PLL(usb), .AUX_DIVIDER_FROM_AUX(fax),
    .AUX_OSC_MODE(mode), .AUX_PLL_SOURCE(src), .AUX_PLL_OUT_DIV(post),
    .AUX_PLL_PRE_DIV(pre), .AUX_PLL_MULT(mult));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // Extra idle edge so back-to-back calls never drive a strobe twice
  task automatic wr_reg(logic [1:0] a, logic [15:0] d);
    adr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(logic [1:0] a, logic [15:0] e);
    adr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdat);
    @(posedge clk);
  endtask
  // Pulses one source every other cycle and counts pin toggles
  task automatic tick(logic s, logic x, int k, int e, string nm);
    logic p;
    n = 0;
    p = pin;
    for (int i = 0; i < 2 * k + 6; i++) begin
      st <= s & (i < 2 * k) & ~i[0];
      xt <= x & (i < 2 * k) & ~i[0];
      @(negedge clk) n += int'(pin !== p);
      p = pin;
      @(posedge clk);
    end
    chk(nm, 16'(e), 16'(n));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      w = {c[0], 1'b0, c[1], c[1:0], c[2], c[0], 1'b0, c, 2'h0, c};
      wr_reg(2'h1, w);
      wr_reg(2'h2, {13'h0000, c});
      rd_chk(2'h1, w & rcc_pkg::MASK_AUXCTL);
      chk("pll_en", c[0], pen);
      chk("usb", c[0], usb);
      chk("dsrc", c[1], fax);
      chk("mode", c[1:0], mode);
      chk("src", c[0] ? 2'h2 : {1'b0, c[2]}, src);
      chk("post", post_e[k], post);
      chk("pre", pre_e[k], pre);
      chk("mult", mul_e[k], mult);
    end
    $display("test rows done");
    wr_reg(2'h0, 16'h8000);
    tick(1'b1, 1'b0, 8, 8, "div1");
    chk("oe", 1'b1, oe);
    tick(1'b0, 1'b1, 8, 0, "xtal_off");
    wr_reg(2'h0, 16'h0000);
    tick(1'b1, 1'b0, 4, 0, "disabled");
    chk("oe", 1'b0, oe);
    wr_reg(2'h0, 16'h9200);
    tick(1'b0, 1'b1, 8, 2, "div4");
    slp <= 1'b1;
    tick(1'b0, 1'b1, 8, 0, "sleep");
    chk("oe", 1'b1, oe);
    wr_reg(2'h0, 16'h0000);
    wr_reg(2'h0, 16'hB000);
    tick(1'b0, 1'b1, 8, 8, "run_sleep");
    slp <= 1'b0;
    $display("test ref_clock_out_pin done");
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) rd_chk(2'(a), 16'h0000);
    chk("post", 16'h0100, post);
    chk("pre", 16'h0001, pre);
    chk("mult", 16'h000F, mult);
    chk("mode", 16'h0000, mode);
    $display("test reset done");
    final_report();
  end
endmodule
`default_nettype wire
